//--- hw/scc_pkg.sv
// Shared constants, types and helpers for the serializer configuration block.
package scc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LINK_CFG1 = 8'h04;
    localparam logic [7:0] ADDR_BUS_CTRL = 8'h05;
    localparam logic [7:0] RST_LINK_CFG1 = 8'h80;
    localparam logic [7:0] RST_BUS_CTRL = 8'h00;
    localparam logic [7:0] MASK_LINK_CFG1 = 8'haf;
    localparam logic [7:0] MASK_BUS_CTRL = 8'h1f;

    localparam int CFG1_FAILSAFE_BIT = 7;
    localparam int CFG1_CRC_CLEAR_BIT = 5;
    localparam int CFG1_LEGACY_SRC_BIT = 3;
    localparam int CFG1_LEGACY_BIT = 2;
    localparam int CFG1_LFR_SRC_BIT = 1;
    localparam int CFG1_LFR_BIT = 0;
    localparam int CTRL_SDA_DLY_LSB = 3;
    localparam int CTRL_WR_BLOCK_BIT = 2;
    localparam int CTRL_WD_FAST_BIT = 1;
    localparam int CTRL_WD_OFF_BIT = 0;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 125_000_000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int WD_LONG_S = 1;
    localparam int WD_SHORT_MS = 50;
    localparam int WD_LONG_CYC = WD_LONG_S * CLK_FREQ_HZ;
    localparam int WD_SHORT_CYC = WD_SHORT_MS * (CLK_FREQ_HZ / 1000);
    localparam int RECOVER_HALF_NS = 5000;
    localparam int RECOVER_HALF_CYC = RECOVER_HALF_NS / CLK_PERIOD_NS;
    localparam int RECOVER_PULSES = 9;
    localparam int SDA_DLY_BASE_NS = 240;
    localparam int SDA_DLY_STEP_NS = 40;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // Arbitrary neutral slave address.
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        S_IDLE, S_ADDR, S_ACK_ADDR, S_REGP, S_ACK_REGP,
        S_WDAT, S_ACK_WDAT, S_RDAT, S_ACK_RDAT
    } scc_i2c_state_t;

    typedef enum logic {WD_WATCH, WD_PULSE} scc_wd_state_t;

    // Clock cycles from an SCL fall to the SDA update.
    function automatic logic [5:0] scc_sda_dly_cyc(input logic [1:0] sel);
        int ns;
        ns = SDA_DLY_BASE_NS + SDA_DLY_STEP_NS * int'(sel);
        return 6'(ns / CLK_PERIOD_NS);
    endfunction

endpackage

//--- hw/scc_bus_watchdog.sv
// Serial bus inactivity watchdog with idle detection and stuck-bus recovery.
`timescale 1ns/1ps
module scc_bus_watchdog import scc_pkg::*; #(
    parameter int LONG_CYC = WD_LONG_CYC,
    parameter int SHORT_CYC = WD_SHORT_CYC,
    parameter int HALF_CYC = RECOVER_HALF_CYC,
    parameter int CNT_W = 27,
    parameter int HALF_W = 16
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic enable_in,
    input wire logic fast_in,
    input wire logic sda_in,
    input wire logic activity_in,
    output logic bus_free_out,
    output logic scl_oe_out,
    output logic recovering_out
);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    scc_wd_state_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d, limit;
    logic [HALF_W-1:0] half_q, half_d;
    logic [4:0] edges_q, edges_d;
    logic scl_oe_q, scl_oe_d, free_q, free_d, idle_q, idle_d;

    always_comb begin
        limit = fast_in ? CNT_W'(SHORT_CYC - 1) : CNT_W'(LONG_CYC - 1); // [R9]
        st_d = st_q;
        cnt_d = cnt_q;
        half_d = half_q;
        edges_d = edges_q;
        scl_oe_d = scl_oe_q;
        free_d = 1'b0;
        idle_d = idle_q;
        unique case (st_q)
            WD_WATCH: begin
                scl_oe_d = 1'b0;
                if (!enable_in || activity_in) begin
                    cnt_d = '0; // [R10]
                    if (activity_in) begin
                        idle_d = 1'b0;
                    end
                end else if (cnt_q >= limit) begin
                    cnt_d = '0;
                    if (sda_in) begin
                        // Report a free bus once per quiet spell, not every period.
                        free_d = !idle_q; // [R11]
                        idle_d = 1'b1;
                    end else begin
                        st_d = WD_PULSE; // [R12]
                        half_d = '0;
                        edges_d = '0;
                        scl_oe_d = 1'b1;
                    end
                end else begin
                    cnt_d = cnt_q + CNT_W'(1);
                end
            end
            WD_PULSE: begin
                if (!enable_in) begin
                    st_d = WD_WATCH; // [R10]
                    scl_oe_d = 1'b0;
                    cnt_d = '0;
                end else if (half_q == HALF_W'(HALF_CYC - 1)) begin
                    half_d = '0;
                    edges_d = edges_q + 5'h01;
                    if (edges_q == 5'(2 * RECOVER_PULSES - 1)) begin
                        st_d = WD_WATCH; // [R12]
                        scl_oe_d = 1'b0;
                        cnt_d = '0;
                    end else begin
                        scl_oe_d = ~scl_oe_q;
                    end
                end else begin
                    half_d = half_q + HALF_W'(1);
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= WD_WATCH;
            cnt_q <= '0;
            half_q <= '0;
            edges_q <= '0;
            scl_oe_q <= 1'b0;
            free_q <= 1'b0;
            idle_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            half_q <= half_d;
            edges_q <= edges_d;
            scl_oe_q <= scl_oe_d;
            free_q <= free_d;
            idle_q <= idle_d;
        end
    end

    assign bus_free_out = free_q;
    assign scl_oe_out = scl_oe_q;
    assign recovering_out = (st_q == WD_PULSE);

endmodule

//--- hw/scc_serializer_config.sv
// Serial-bus configuration slave holding the link and bus control registers.
//
// Overview of operation
// [R1] Counter-clear bit holds CRC error counters cleared until software writes zero.
// [R2] Legacy-compat source bit picks register bit or strap pin.
// [R3] Legacy-compat register bit enables old-deserializer compatibility; default off.
// [R4] Frequency-range source bit picks register bit or strap pin.
// [R5] Low-frequency bit one selects 5 to 15 MHz, zero selects 15 to 85 MHz.
// [R6] Two-bit field sets SCL-to-SDA output delay 240 to 360 ns, 40 ns steps.
// [R7] Write-block bit refuses far-end writes to the local registers.
// [R8] Write-block bit never stops far-end access to local-side slaves.
// [R9] Watchdog expires after about 1 s, or about 50 ms when sped up.
// [R10] Watchdog-disable bit stops all watchdog detection and action.
// [R11] Quiet bus with SDA high for the timeout is treated as free.
// [R12] SDA stuck low at timeout triggers nine SCL clock pulses.
// [R13] Reserved bits read zero and writes to them do nothing.
`timescale 1ns/1ps
module scc_serializer_config import scc_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT,
    parameter int WD_LONG = WD_LONG_CYC,
    parameter int WD_SHORT = WD_SHORT_CYC,
    parameter int WD_HALF = RECOVER_HALF_CYC
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe_out,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic strap_legacy_compat_in,
    input wire logic strap_low_freq_in,
    input wire logic remote_req_in,
    input wire logic remote_local_in,
    input wire logic remote_wr_in,
    input wire logic [7:0] remote_addr_in,
    input wire logic [7:0] remote_wdata_in,
    output logic remote_done_out,
    output logic remote_refused_out,
    output logic [7:0] remote_rdata_out,
    output logic remote_fwd_out,
    output logic failsafe_low_out,
    output logic crc_clear_out,
    output logic legacy_compat_out,
    output logic low_frequency_range_out
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic scl_m_q, scl_s_q, scl_p_q;
    logic sda_m_q, sda_s_q, sda_p_q;
    logic lc_m_q, lc_s_q, lf_m_q, lf_s_q;
    logic scl_rise, scl_fall, start_det, stop_det, activity;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            lc_m_q <= 1'b0;
            lc_s_q <= 1'b0;
            lf_m_q <= 1'b0;
            lf_s_q <= 1'b0;
        end else begin
            scl_m_q <= scl_in;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_in;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            lc_m_q <= strap_legacy_compat_in;
            lc_s_q <= lc_m_q;
            lf_m_q <= strap_low_freq_in;
            lf_s_q <= lf_m_q;
        end
    end

    assign scl_rise = scl_s_q & ~scl_p_q;
    assign scl_fall = ~scl_s_q & scl_p_q;
    assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
    assign activity = (scl_s_q ^ scl_p_q) | (sda_s_q ^ sda_p_q);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] cfg1_q, cfg1_d, ctrl_q, ctrl_d;
    logic [7:0] rdata_q, rdata_d;
    logic done_q, done_d, refused_q, refused_d, fwd_q, fwd_d;
    logic legacy_q, legacy_d, lfr_q, lfr_d;
    logic i2c_wr, rem_take, rem_wr_ok;
    logic [7:0] i2c_waddr, i2c_wdata;

    // Unmapped addresses read as zero; reserved bits are never stored.
    function automatic logic [7:0] reg_read(input logic [7:0] addr);
        logic [7:0] v;
        v = 8'h00;
        if (addr == ADDR_LINK_CFG1) begin
            v = cfg1_q & MASK_LINK_CFG1; // [R13]
        end else if (addr == ADDR_BUS_CTRL) begin
            v = ctrl_q & MASK_BUS_CTRL; // [R13]
        end
        return v;
    endfunction

    always_comb begin
        cfg1_d = cfg1_q;
        ctrl_d = ctrl_q;
        rem_take = remote_req_in & remote_local_in;
        rem_wr_ok = rem_take & remote_wr_in & ~ctrl_q[CTRL_WR_BLOCK_BIT]; // [R7]
        refused_d = rem_take & remote_wr_in & ctrl_q[CTRL_WR_BLOCK_BIT]; // [R7]
        done_d = rem_take & ~refused_d;
        fwd_d = remote_req_in & ~remote_local_in; // [R8]
        rdata_d = rdata_q;
        if (rem_take && !remote_wr_in) begin
            rdata_d = reg_read(remote_addr_in);
        end
        // A far-end write lands first so a same-cycle local write wins the register.
        if (rem_wr_ok && remote_addr_in == ADDR_LINK_CFG1) begin
            cfg1_d = remote_wdata_in & MASK_LINK_CFG1; // [R13]
        end
        if (rem_wr_ok && remote_addr_in == ADDR_BUS_CTRL) begin
            ctrl_d = remote_wdata_in & MASK_BUS_CTRL; // [R13]
        end
        if (i2c_wr && i2c_waddr == ADDR_LINK_CFG1) begin
            cfg1_d = i2c_wdata & MASK_LINK_CFG1; // [R13]
        end
        if (i2c_wr && i2c_waddr == ADDR_BUS_CTRL) begin
            ctrl_d = i2c_wdata & MASK_BUS_CTRL; // [R13]
        end
        legacy_d = cfg1_q[CFG1_LEGACY_SRC_BIT] ? cfg1_q[CFG1_LEGACY_BIT] : lc_s_q; // [R2] [R3]
        lfr_d = cfg1_q[CFG1_LFR_SRC_BIT] ? cfg1_q[CFG1_LFR_BIT] : lf_s_q; // [R4] [R5]
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cfg1_q <= RST_LINK_CFG1;
            ctrl_q <= RST_BUS_CTRL;
            rdata_q <= 8'h00;
            done_q <= 1'b0;
            refused_q <= 1'b0;
            fwd_q <= 1'b0;
            legacy_q <= 1'b0;
            lfr_q <= 1'b0;
        end else begin
            cfg1_q <= cfg1_d;
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
            done_q <= done_d;
            refused_q <= refused_d;
            fwd_q <= fwd_d;
            legacy_q <= legacy_d;
            lfr_q <= lfr_d;
        end
    end

    assign failsafe_low_out = cfg1_q[CFG1_FAILSAFE_BIT];
    assign crc_clear_out = cfg1_q[CFG1_CRC_CLEAR_BIT]; // [R1]
    assign legacy_compat_out = legacy_q;
    assign low_frequency_range_out = lfr_q;
    assign remote_done_out = done_q;
    assign remote_refused_out = refused_q;
    assign remote_rdata_out = rdata_q;
    assign remote_fwd_out = fwd_q;

    // ------------------------------------------------------------
    // Bus watchdog
    // ------------------------------------------------------------
    logic wd_free, wd_recover;

    scc_bus_watchdog #(
        .LONG_CYC(WD_LONG),
        .SHORT_CYC(WD_SHORT),
        .HALF_CYC(WD_HALF)
    ) u_wd (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .enable_in(~ctrl_q[CTRL_WD_OFF_BIT]), // [R10]
        .fast_in(ctrl_q[CTRL_WD_FAST_BIT]), // [R9]
        .sda_in(sda_s_q),
        .activity_in(activity),
        .bus_free_out(wd_free),
        .scl_oe_out(scl_oe_out),
        .recovering_out(wd_recover)
    );

    assign scl_out = 1'b0;
    assign sda_out = 1'b0;

    // ------------------------------------------------------------
    // Serial slave protocol
    // ------------------------------------------------------------
    scc_i2c_state_t st_q, st_d;
    logic [7:0] shift_q, shift_d, ptr_q, ptr_d;
    logic [3:0] cnt_q, cnt_d;
    logic rw_q, rw_d, nack_q, nack_d;

    assign i2c_waddr = ptr_q;
    assign i2c_wdata = shift_q;

    always_comb begin
        st_d = st_q;
        shift_d = shift_q;
        ptr_d = ptr_q;
        cnt_d = cnt_q;
        rw_d = rw_q;
        nack_d = nack_q;
        i2c_wr = 1'b0;
        // Our own recovery clocks must not be decoded as a transfer.
        if (wd_recover || wd_free) begin
            st_d = S_IDLE; // [R11] [R12]
        end else if (start_det) begin
            st_d = S_ADDR;
            cnt_d = 4'h0;
        end else if (stop_det) begin
            st_d = S_IDLE;
        end else begin
            unique case (st_q)
                S_IDLE: begin
                end
                S_ADDR, S_REGP, S_WDAT: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_s_q};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BYTE_BITS) begin
                        cnt_d = 4'h0;
                        if (st_q == S_ADDR) begin
                            if (shift_q[7:1] == DEV_ADDR) begin
                                rw_d = shift_q[0];
                                st_d = S_ACK_ADDR;
                            end else begin
                                st_d = S_IDLE;
                            end
                        end else if (st_q == S_REGP) begin
                            ptr_d = shift_q;
                            st_d = S_ACK_REGP;
                        end else begin
                            i2c_wr = 1'b1;
                            st_d = S_ACK_WDAT;
                        end
                    end
                end
                S_ACK_ADDR: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            st_d = S_RDAT;
                            shift_d = reg_read(ptr_q);
                        end else begin
                            st_d = S_REGP;
                        end
                    end
                end
                S_ACK_REGP: begin
                    if (scl_fall) begin
                        st_d = S_WDAT;
                    end
                end
                S_ACK_WDAT: begin
                    if (scl_fall) begin
                        st_d = S_WDAT;
                        ptr_d = ptr_q + 8'h01;
                    end
                end
                S_RDAT: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == BYTE_BITS) begin
                            cnt_d = 4'h0;
                            st_d = S_ACK_RDAT;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                        end
                    end
                end
                S_ACK_RDAT: begin
                    if (scl_rise) begin
                        nack_d = sda_s_q;
                    end else if (scl_fall) begin
                        if (nack_q) begin
                            st_d = S_IDLE;
                        end else begin
                            ptr_d = ptr_q + 8'h01;
                            shift_d = reg_read(ptr_q + 8'h01);
                            st_d = S_RDAT;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st_q <= S_IDLE;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            cnt_q <= 4'h0;
            rw_q <= 1'b0;
            nack_q <= 1'b0;
        end else begin
            st_q <= st_d;
            shift_q <= shift_d;
            ptr_q <= ptr_d;
            cnt_q <= cnt_d;
            rw_q <= rw_d;
            nack_q <= nack_d;
        end
    end

    // ------------------------------------------------------------
    // Delayed SDA drive
    // ------------------------------------------------------------
    logic [5:0] dly_q, dly_d;
    logic run_q, run_d, oe_q, oe_d, want;

    // The delay counts from the synchronised fall, so pin delay adds two cycles.
    always_comb begin
        want = (st_q == S_ACK_ADDR) || (st_q == S_ACK_REGP) || (st_q == S_ACK_WDAT) ||
               (st_q == S_RDAT && !shift_q[7]);
        dly_d = dly_q;
        run_d = run_q;
        oe_d = oe_q;
        if (st_q == S_IDLE) begin
            oe_d = 1'b0;
            run_d = 1'b0;
        end else if (scl_fall) begin
            dly_d = scc_sda_dly_cyc(ctrl_q[CTRL_SDA_DLY_LSB +: 2]); // [R6]
            run_d = 1'b1;
        end else if (run_q) begin
            if (dly_q == 6'h00) begin
                oe_d = want; // [R6]
                run_d = 1'b0;
            end else begin
                dly_d = dly_q - 6'h01;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            dly_q <= 6'h00;
            run_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            dly_q <= dly_d;
            run_q <= run_d;
            oe_q <= oe_d;
        end
    end

    assign sda_oe_out = oe_q;

endmodule

//--- tb/scc_chk_sva.sv
// Port-level assertions for the serializer configuration block.
`timescale 1ns/1ps
module scc_chk_sva #(
    parameter int WD_HALF = 8
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe_out,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic remote_req_in,
    input wire logic remote_local_in,
    input wire logic remote_wr_in,
    input wire logic remote_done_out,
    input wire logic remote_refused_out,
    input wire logic [7:0] remote_rdata_out,
    input wire logic remote_fwd_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic [15:0] hi_cnt_q;
    logic [15:0] hi_cnt_d;
    // Counts the low half of a recovery pulse, so a short or long pulse shows.
    always_comb begin
        hi_cnt_d = scl_oe_out ? hi_cnt_q + 16'h1 : 16'h0;
    end
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hi_cnt_q <= 16'h0;
        end else begin
            hi_cnt_q <= hi_cnt_d;
        end
    end
    sequence s_rd;
        remote_req_in && remote_local_in && !remote_wr_in;
    endsequence
    sequence s_wr;
        remote_req_in && remote_local_in && remote_wr_in;
    endsequence
    chk_read_done: assert property (s_rd |=> remote_done_out && !remote_refused_out)
        else $error("local read not answered");
    chk_write_answer: assert property (s_wr |=> remote_done_out != remote_refused_out)
        else $error("local write without single answer");
    chk_fwd_only: assert property (remote_req_in && !remote_local_in |=>
        remote_fwd_out && !remote_done_out && !remote_refused_out)
        else $error("far access not forwarded");
    chk_quiet_idle: assert property (!remote_req_in |=>
        !(remote_done_out || remote_fwd_out || remote_refused_out))
        else $error("answer without request");
    chk_done_cause: assert property (remote_done_out |->
        $past(remote_req_in && remote_local_in))
        else $error("done without local request");
    chk_rdata_hold: assert property (!$past(remote_req_in) |-> $stable(remote_rdata_out))
        else $error("read data moved without request");
    chk_pulse_width: assert property ($fell(scl_oe_out) |-> hi_cnt_q == 16'(WD_HALF))
        else $error("recovery pulse width wrong");
    chk_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("bus data level not low");
    chk_sda_delay: assert property ($fell(scl_in) |=> $stable(sda_oe_out) [*8])
        else $error("data line answered before its delay");
endmodule
bind scc_serializer_config scc_chk_sva #(.WD_HALF(WD_HALF)) i_scc_chk_sva (.*);

//--- tb/scc_i2c_host.sv
// Behavioural serial-bus host that drives the control bus of the block.
`timescale 1ns/1ps
module scc_i2c_host #(
    parameter int HALF = 120
) (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_low_out,
    output logic sda_low_out
);
    // Both lines released at start so the pull-ups hold the bus idle.
    initial begin
        scl_low_out = 1'b0;
        sda_low_out = 1'b0;
    end
    // Half period is well above the slowest answer delay, so ACK is set up in time.
    task automatic hw();
        repeat (HALF) @(posedge clk_in);
        #1;
    endtask
    task automatic start();
        sda_low_out = 1'b0;
        hw();
        scl_low_out = 1'b0;
        hw();
        sda_low_out = 1'b1;
        hw();
        scl_low_out = 1'b1;
    endtask
    task automatic stop();
        sda_low_out = 1'b1;
        hw();
        scl_low_out = 1'b0;
        hw();
        sda_low_out = 1'b0;
        hw();
    endtask
    task automatic byte9(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_low_out = !tx[i];
            hw();
            scl_low_out = 1'b0;
            hw();
            rx[i] = sda_in;
            scl_low_out = 1'b1;
        end
    endtask
    // Leaves SCL high and SDA at the given state with no further signalling.
    task automatic park(input logic lo);
        scl_low_out = 1'b0;
        sda_low_out = lo;
    endtask
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the serializer configuration block.
`timescale 1ns/1ps
module tb_top;
    logic clk_in, rst_in, scl_oe, sda_oe, h_scl, h_sda, s_leg, s_lfr, req, loc, wr;
    logic done, refused, fwd, fs, crc, leg, lfr, scl_w, sda_w, scl_do, sda_do;
    logic [7:0] addr, wdata, rdata;
    logic [8:0] rx;
    int mismatches = 0;
    int cmp_count = 0;
    // Open-drain wires with pull-ups.
    assign scl_w = !(h_scl | (scl_oe & !scl_do));
    assign sda_w = !(h_sda | (sda_oe & !sda_do));
    scc_serializer_config #(.WD_LONG(200), .WD_SHORT(100), .WD_HALF(8))
    i_scc_serializer_config (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl_w), .sda_in(sda_w),
        .scl_out(scl_do), .scl_oe_out(scl_oe), .sda_out(sda_do), .sda_oe_out(sda_oe),
        .strap_legacy_compat_in(s_leg), .strap_low_freq_in(s_lfr), .remote_req_in(req),
        .remote_local_in(loc), .remote_wr_in(wr), .remote_addr_in(addr),
        .remote_wdata_in(wdata), .remote_done_out(done), .remote_refused_out(refused),
        .remote_rdata_out(rdata), .remote_fwd_out(fwd), .failsafe_low_out(fs),
        .crc_clear_out(crc), .legacy_compat_out(leg), .low_frequency_range_out(lfr));
    scc_i2c_host i_scc_i2c_host (.clk_in(clk_in), .sda_in(sda_w), .scl_low_out(h_scl),
        .sda_low_out(h_sda));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // One-cycle far-end request; the answer pulse is live when this returns.
    task automatic rem(input logic l, input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        req = 1'b1;
        loc = l;
        wr = w;
        addr = a;
        wdata = d;
        @(posedge clk_in);
        #1;
        req = 1'b0;
    endtask
    task automatic tx(input logic [7:0] b);
        logic [8:0] r;
        i_scc_i2c_host.byte9({b, 1'b1}, r);
        chk({7'h0, r[0]}, 8'h00);
    endtask
    // Counts recovery pulses seen on SCL over n cycles.
    task automatic wd(input int n, input logic [7:0] exp);
        int r;
        logic p;
        r = 0;
        p = 1'b0;
        repeat (n) begin
            @(posedge clk_in);
            #1;
            if (scl_oe && !p) r++;
            p = scl_oe;
        end
        chk(8'(r), exp);
    endtask
    initial begin
        repeat (60000) @(posedge clk_in);
        mismatches++;
        wrap_up();
    end
    initial begin
        {rst_in, req, loc, wr, addr, wdata, s_leg, s_lfr} = {4'b1000, 18'h0};
        repeat (5) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        repeat (4) @(posedge clk_in);
        rem(1, 0, 8'h04, 8'h00);
        chk(rdata, 8'h80);
        rem(1, 0, 8'h05, 8'h00);
        chk(rdata, 8'h00);
        rem(1, 0, 8'h07, 8'h00);
        chk({5'h0, done, rdata[1:0]}, 8'h04);
        chk({6'h0, fs, crc}, 8'h02);
        rem(1, 1, 8'h05, 8'h04);
        chk({5'h0, done, refused, fwd}, 8'h04);
        rem(1, 1, 8'h04, 8'h00);
        chk({5'h0, done, refused, fwd}, 8'h02);
        rem(1, 0, 8'h04, 8'h00);
        chk(rdata, 8'h80);
        rem(0, 1, 8'h04, 8'h00);
        chk({5'h0, done, refused, fwd}, 8'h01);
        i_scc_i2c_host.start();
        tx(8'h54);
        tx(8'h04);
        tx(8'hff);
        tx(8'h18);
        i_scc_i2c_host.stop();
        i_scc_i2c_host.start();
        tx(8'h54);
        tx(8'h04);
        i_scc_i2c_host.start();
        tx(8'h55);
        i_scc_i2c_host.byte9({8'hff, 1'b0}, rx);
        chk(rx[8:1], 8'haf);
        i_scc_i2c_host.byte9({8'hff, 1'b1}, rx);
        chk(rx[8:1], 8'h18);
        i_scc_i2c_host.stop();
        chk({4'h0, fs, crc, leg, lfr}, 8'h0f);
        {s_leg, s_lfr} = 2'b11;
        rem(1, 1, 8'h04, 8'h8a);
        repeat (5) @(posedge clk_in);
        chk({4'h0, fs, crc, leg, lfr}, 8'h08);
        rem(1, 1, 8'h04, 8'h80);
        repeat (5) @(posedge clk_in);
        chk({4'h0, fs, crc, leg, lfr}, 8'h0b);
        s_leg = 1'b0;
        repeat (5) @(posedge clk_in);
        chk({4'h0, fs, crc, leg, lfr}, 8'h09);
        rem(1, 1, 8'h05, 8'h02);
        i_scc_i2c_host.park(1'b1);
        wd(300, 8'h09);
        i_scc_i2c_host.park(1'b0);
        wd(300, 8'h00);
        rem(1, 1, 8'h05, 8'h00);
        i_scc_i2c_host.park(1'b1);
        wd(190, 8'h00);
        wd(210, 8'h09);
        i_scc_i2c_host.park(1'b0);
        rem(1, 1, 8'h05, 8'h03);
        i_scc_i2c_host.park(1'b1);
        wd(400, 8'h00);
        i_scc_i2c_host.park(1'b0);
        wrap_up();
    end
endmodule
